// File: design/link_handshake_defs.vh
`ifndef LINK_HANDSHAKE_DEFS_VH
`define LINK_HANDSHAKE_DEFS_VH

// per-link register block: base + stride * link
`define LINK_STRIDE      12'h010
`define RA_CTL_OFF       4'h0
`define RA_STAT_OFF      4'h4
`define HA_CTL_OFF       4'h8
`define HA_STAT_OFF      4'hc
// link-agent gateway and node info
`define LA_CTL_ADDR      12'h100
`define LA_STAT_ADDR     12'h104
`define NODE_INFO_LO     12'h108
`define NODE_INFO_HI     12'h10c

// gateway control bits
`define CTL_ALLOW_BIT    0
`define CTL_REQ_BIT      1
`define CTL_GO_BIT       2
// gateway status bits
`define STAT_ACK_BIT     0
`define STAT_DRAINED_BIT 1
`define STAT_PCB_BIT     2
// link-agent control / status fields
`define LA_MASK_LSB      0
`define LA_MASK_W        16
`define LA_FWD_REQ_BIT   16
`define LA_FWD_ACK_BIT   0
`define LA_FWD_ST_LSB    1

// forwarding status codes
`define FWD_OFF          2'h0
`define FWD_ACTIVATING   2'h1
`define FWD_RUN          2'h2
`define FWD_DEACTIVATING 2'h3

// reset values
`define CTL_RESET        3'h0
`define LA_MASK_RESET    16'h0000

`endif

// File: design/link_fsm.v
`timescale 1ns/1ps
`include "link_handshake_defs.vh"

module link_fsm #(
	parameter CREDITS = 8,
	parameter CNT_W   = 4
) (
	// clock and reset
	input  wire pclk,
	input  wire presetn,
	// software control, both gateways combined
	input  wire allow_all,
	input  wire req_all,
	input  wire req_none,
	input  wire go_all,
	input  wire go_none,
	// remote side, already synchronised
	input  wire remote_ready,
	input  wire remote_grant_ev,
	input  wire remote_return_ev,
	// status and link side
	output reg  ack_q,
	output reg  drained_q,
	output reg  active_q,
	output reg  grant_tgl_q,
	output reg  return_tgl_q
);

	localparam S_DOWN  = 6'b000001;
	localparam S_ACK   = 6'b000010;
	localparam S_UP    = 6'b000100;
	localparam S_RUN   = 6'b001000;
	localparam S_DRAIN = 6'b010000;
	localparam S_DONE  = 6'b100000;

	reg [5:0]       state_q;
	reg [CNT_W-1:0] given_q;
	reg [CNT_W-1:0] held_q;

	// counter step with saturation at both ends
	function [CNT_W-1:0] step;
		input [CNT_W-1:0] v;
		input             inc;
		input             dec;
		begin
			step = v;
			if (inc && !dec && v != {CNT_W{1'b1}})
				step = v + {{(CNT_W-1){1'b0}}, 1'b1};
			else if (dec && !inc && v != {CNT_W{1'b0}})
				step = v - {{(CNT_W-1){1'b0}}, 1'b1};
		end
	endfunction

	wire grant_now  = (state_q == S_RUN) && (given_q < CREDITS[CNT_W-1:0]);
	wire return_now = (state_q == S_DRAIN) && (held_q != {CNT_W{1'b0}});
	wire live       = (state_q == S_RUN) || (state_q == S_DRAIN);

	// handshake sequence and credit bookkeeping
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q      <= S_DOWN;
			ack_q        <= 1'b0;
			drained_q    <= 1'b1;
			active_q     <= 1'b0;
			grant_tgl_q  <= 1'b0;
			return_tgl_q <= 1'b0;
			given_q      <= {CNT_W{1'b0}};
			held_q       <= {CNT_W{1'b0}};
		end
		else
		begin
			// remote events only count while the link is live
			given_q <= step(given_q, grant_now, live && remote_return_ev);
			held_q  <= step(held_q, live && remote_grant_ev, return_now);
			if (grant_now)
				grant_tgl_q <= ~grant_tgl_q; // grants only while running
			if (return_now)
				return_tgl_q <= ~return_tgl_q; // hand back remote credits
			case (state_q)
				S_DOWN:
				begin
					active_q <= 1'b0;
					// accept only with the remote side credit-ready
					if (allow_all && req_all && go_none && remote_ready)
					begin
						ack_q   <= 1'b1; // ack first
						state_q <= S_ACK;
					end
				end
				S_ACK:
				begin
					drained_q <= 1'b0; // then drained falls
					state_q   <= S_UP;
				end
				S_UP:
				begin
					if (req_none)
					begin
						ack_q     <= 1'b0;
						drained_q <= 1'b1;
						state_q   <= S_DOWN;
					end
					else if (go_all)
					begin
						active_q <= 1'b1;
						state_q  <= S_RUN; // start granting
					end
				end
				S_RUN:
				begin
					if (req_none)
					begin
						ack_q   <= 1'b0; // link-down accepted
						state_q <= S_DRAIN;
					end
				end
				S_DRAIN:
				begin
					// all own credits back and nothing held
					if (given_q == {CNT_W{1'b0}} && held_q == {CNT_W{1'b0}})
					begin
						drained_q <= 1'b1;
						state_q   <= S_DONE;
					end
				end
				S_DONE:
				begin
					if (go_none)
					begin
						active_q <= 1'b0; // link down, nothing crosses
						state_q  <= S_DOWN;
					end
				end
				default:
				begin
					state_q <= S_DOWN;
				end
			endcase
		end
	end

endmodule // link_fsm

// File: design/link_handshake.v
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "link_handshake_defs.vh"

module link_handshake #(
	parameter NUM_LINKS           = 3,
	parameter CREDITS             = 8,
	parameter CNT_W               = 4,
	parameter PORT_LOGICAL_NUMBER = 16'h0000
) (
	// clock and reset
	input  wire                 pclk,
	input  wire                 presetn,
	// apb slave
	input  wire                 psel,
	input  wire                 penable,
	input  wire                 pwrite,
	input  wire [11:0]          paddr,
	input  wire [31:0]          pwdata,
	output reg                  pready,
	output reg  [31:0]          prdata,
	output reg                  pslverr,
	// local request-agent state
	input  wire [NUM_LINKS-1:0] pending_copyback_flag,
	// remote agent, asynchronous
	input  wire [NUM_LINKS-1:0] remote_ready,
	input  wire [NUM_LINKS-1:0] remote_grant_tgl,
	input  wire [NUM_LINKS-1:0] remote_return_tgl,
	// credit and link outputs
	output wire [NUM_LINKS-1:0] credit_grant_tgl,
	output wire [NUM_LINKS-1:0] credit_return_tgl,
	output wire [NUM_LINKS-1:0] link_active,
	// port forwarding
	output reg  [15:0]          fwd_src_mask,
	output reg                  fwd_enable
);

	// gateway control bits, one bit per link, then the forwarding request and ack
	reg [NUM_LINKS-1:0] ra_allow_q;
	reg [NUM_LINKS-1:0] ra_req_q;
	reg [NUM_LINKS-1:0] ra_go_q;
	reg [NUM_LINKS-1:0] ha_allow_q;
	reg [NUM_LINKS-1:0] ha_req_q;
	reg [NUM_LINKS-1:0] ha_go_q;
	reg                 fwd_req_q;
	reg                 fwd_ack_q;

	// synchronisers for the remote inputs
	reg [NUM_LINKS-1:0] rdy_s1_q;
	reg [NUM_LINKS-1:0] rdy_s2_q;
	reg [NUM_LINKS-1:0] gnt_s1_q;
	reg [NUM_LINKS-1:0] gnt_s2_q;
	reg [NUM_LINKS-1:0] gnt_s3_q;
	reg [NUM_LINKS-1:0] ret_s1_q;
	reg [NUM_LINKS-1:0] ret_s2_q;
	reg [NUM_LINKS-1:0] ret_s3_q;

	wire [NUM_LINKS-1:0] ack;
	wire [NUM_LINKS-1:0] drained;

	// one-cycle event per edge of a remote toggle
	wire [NUM_LINKS-1:0] gnt_ev = gnt_s2_q ^ gnt_s3_q;
	wire [NUM_LINKS-1:0] ret_ev = ret_s2_q ^ ret_s3_q;

	// address decode; unaligned words fall to the refused path
	wire        aligned   = (paddr[1:0] == 2'b00);
	wire        link_area = (paddr[11:8] == 4'h0);
	wire [3:0]  link_idx  = paddr[7:4];
	wire [3:0]  reg_off   = {paddr[3:2], 2'b00};
	wire        link_hit  = link_area && aligned && (link_idx < NUM_LINKS);
	wire        access    = psel && penable;

	reg  [31:0] rdata_d;
	reg         err_d;
	integer     i;
	integer     j;

	// true when address a picks register off of link n
	function link_reg;
		input [11:0] a;
		input integer n;
		input [3:0] off;
		begin
			link_reg = (a[11:8] == 4'h0) && (a[1:0] == 2'b00) && (a[7:4] == n)
				&& ({a[3:2], 2'b00} == off);
		end
	endfunction

	// forwarding state from request and ack
	function [1:0] fwd_code;
		input req;
		input ack;
		begin
			case ({req, ack})
				2'b10:   fwd_code = `FWD_ACTIVATING;
				2'b11:   fwd_code = `FWD_RUN;
				2'b01:   fwd_code = `FWD_DEACTIVATING;
				default: fwd_code = `FWD_OFF;
			endcase
		end
	endfunction

	// read mux and unmapped detection
	always @*
	begin
		rdata_d = 32'h00000000;
		err_d   = 1'b0;
		if (link_hit)
		begin
			for (i = 0; i < NUM_LINKS; i = i + 1)
			begin
				if (link_idx == i)
				begin
					case (reg_off)
						`RA_CTL_OFF:
						begin
							rdata_d[`CTL_ALLOW_BIT] = ra_allow_q[i];
							rdata_d[`CTL_REQ_BIT]   = ra_req_q[i];
							rdata_d[`CTL_GO_BIT]    = ra_go_q[i];
						end
						`RA_STAT_OFF:
						begin
							rdata_d[`STAT_ACK_BIT]     = ack[i];
							rdata_d[`STAT_DRAINED_BIT] = drained[i];
							rdata_d[`STAT_PCB_BIT]     = pending_copyback_flag[i];
						end
						`HA_CTL_OFF:
						begin
							rdata_d[`CTL_ALLOW_BIT] = ha_allow_q[i];
							rdata_d[`CTL_REQ_BIT]   = ha_req_q[i];
							rdata_d[`CTL_GO_BIT]    = ha_go_q[i];
						end
						default:
						begin
							rdata_d[`STAT_ACK_BIT]     = ack[i];
							rdata_d[`STAT_DRAINED_BIT] = drained[i];
						end
					endcase
				end
			end
		end
		else
		begin
			case (paddr)
				`LA_CTL_ADDR:
				begin
					rdata_d[`LA_MASK_LSB+`LA_MASK_W-1:`LA_MASK_LSB] = fwd_src_mask;
					rdata_d[`LA_FWD_REQ_BIT] = fwd_req_q;
				end
				`LA_STAT_ADDR:
				begin
					rdata_d[`LA_FWD_ACK_BIT] = fwd_ack_q;
					// status code from request and ack
					rdata_d[`LA_FWD_ST_LSB+1:`LA_FWD_ST_LSB] = fwd_code(fwd_req_q, fwd_ack_q);
				end
				`NODE_INFO_LO:
				begin
					rdata_d = 32'h00000000;
				end
				`NODE_INFO_HI:
				begin
					rdata_d[15:0] = PORT_LOGICAL_NUMBER[15:0]; // node info [47:32]
				end
				default:
				begin
					err_d = 1'b1;
				end
			endcase
		end
	end

	// apb answer: one wait state, write lands on the pready edge
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else if (access && !pready)
		begin
			pready  <= 1'b1;
			prdata  <= pwrite ? 32'h00000000 : rdata_d;
			pslverr <= err_d;
		end
		else
		begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end
	end

	wire wr_en = access && pready && pwrite && !pslverr;

	// control register writes
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ra_allow_q   <= {NUM_LINKS{1'b0}};
			ra_req_q     <= {NUM_LINKS{1'b0}};
			ra_go_q      <= {NUM_LINKS{1'b0}};
			ha_allow_q   <= {NUM_LINKS{1'b0}};
			ha_req_q     <= {NUM_LINKS{1'b0}};
			ha_go_q      <= {NUM_LINKS{1'b0}};
			fwd_src_mask <= `LA_MASK_RESET;
			fwd_req_q    <= 1'b0;
		end
		else if (wr_en)
		begin
			for (j = 0; j < NUM_LINKS; j = j + 1)
			begin
				if (link_reg(paddr, j, `RA_CTL_OFF))
				begin
					ra_allow_q[j] <= pwdata[`CTL_ALLOW_BIT];
					ra_req_q[j]   <= pwdata[`CTL_REQ_BIT];
					ra_go_q[j]    <= pwdata[`CTL_GO_BIT];
				end
				if (link_reg(paddr, j, `HA_CTL_OFF))
				begin
					ha_allow_q[j] <= pwdata[`CTL_ALLOW_BIT];
					ha_req_q[j]   <= pwdata[`CTL_REQ_BIT];
					ha_go_q[j]    <= pwdata[`CTL_GO_BIT];
				end
			end
			if (!link_area && paddr == `LA_CTL_ADDR)
			begin
				fwd_src_mask <= pwdata[`LA_MASK_LSB+`LA_MASK_W-1:`LA_MASK_LSB];
				fwd_req_q    <= pwdata[`LA_FWD_REQ_BIT];
			end
		end
	end

	// forwarding ack trails the request by one cycle
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fwd_ack_q  <= 1'b0;
			fwd_enable <= 1'b0;
		end
		else
		begin
			fwd_ack_q  <= fwd_req_q; // walks through activating/deactivating
			fwd_enable <= fwd_req_q && fwd_ack_q;
		end
	end

	// two-flop synchronisers, third stage only for toggle edges
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rdy_s1_q <= {NUM_LINKS{1'b0}};
			rdy_s2_q <= {NUM_LINKS{1'b0}};
			gnt_s1_q <= {NUM_LINKS{1'b0}};
			gnt_s2_q <= {NUM_LINKS{1'b0}};
			gnt_s3_q <= {NUM_LINKS{1'b0}};
			ret_s1_q <= {NUM_LINKS{1'b0}};
			ret_s2_q <= {NUM_LINKS{1'b0}};
			ret_s3_q <= {NUM_LINKS{1'b0}};
		end
		else
		begin
			rdy_s1_q <= remote_ready;
			rdy_s2_q <= rdy_s1_q;
			gnt_s1_q <= remote_grant_tgl;
			gnt_s2_q <= gnt_s1_q;
			gnt_s3_q <= gnt_s2_q;
			ret_s1_q <= remote_return_tgl;
			ret_s2_q <= ret_s1_q;
			ret_s3_q <= ret_s2_q;
		end
	end

	// one handshake engine per link
	genvar g;
	generate
		for (g = 0; g < NUM_LINKS; g = g + 1)
		begin : gen_link
			link_fsm #(
				.CREDITS (CREDITS),
				.CNT_W   (CNT_W)
			) u_fsm (
				.pclk             (pclk),
				.presetn          (presetn),
				.allow_all        (ra_allow_q[g] & ha_allow_q[g]),
				.req_all          (ra_req_q[g] & ha_req_q[g]),
				.req_none         (~ra_req_q[g] & ~ha_req_q[g]),
				.go_all           (ra_go_q[g] & ha_go_q[g]),
				.go_none          (~ra_go_q[g] & ~ha_go_q[g]),
				.remote_ready     (rdy_s2_q[g]),
				.remote_grant_ev  (gnt_ev[g]),
				.remote_return_ev (ret_ev[g]),
				.ack_q            (ack[g]),
				.drained_q        (drained[g]),
				.active_q         (link_active[g]),
				.grant_tgl_q      (credit_grant_tgl[g]),
				.return_tgl_q     (credit_return_tgl[g])
			);
		end
	endgenerate

endmodule // link_handshake

// File: sim/link_handshake_sva.sv
`timescale 1ns/1ps
`include "link_handshake_defs.vh"
module link_checker #(
	parameter NUM_LINKS           = 3,
	parameter CREDITS             = 8,
	parameter PORT_LOGICAL_NUMBER = 16'h0000
) (
	// clock and reset
	input wire                 pclk,
	input wire                 presetn,
	// apb
	input wire                 psel,
	input wire                 penable,
	input wire                 pwrite,
	input wire [11:0]          paddr,
	input wire [31:0]          pwdata,
	input wire                 pready,
	input wire [31:0]          prdata,
	input wire                 pslverr,
	// link and forwarding
	input wire [NUM_LINKS-1:0] credit_grant_tgl,
	input wire [NUM_LINKS-1:0] credit_return_tgl,
	input wire [NUM_LINKS-1:0] link_active,
	input wire [15:0]          fwd_src_mask,
	input wire                 fwd_enable
);
	wire       acc = psel && penable;
	wire       done = acc && pready;
	wire       hole = paddr > `NODE_INFO_HI ||
		(paddr >= 12'h010 * NUM_LINKS && paddr < `LA_CTL_ADDR);
	reg  [7:0] grants_q;
	reg        gseen_q;
	// grants seen in the current active spell of link 0
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			grants_q <= 8'h00;
			gseen_q <= 1'b0;
		end
		else
		begin
			gseen_q <= credit_grant_tgl[0];
			if (!link_active[0])
				grants_q <= 8'h00;
			else if (credit_grant_tgl[0] != gseen_q)
				grants_q <= grants_q + 8'h01;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held too long");
	one_wait_a: assert property (acc && !pready |=> pready)
		else $error("pready late");
	refuse_map_a: assert property (acc && !pready && hole |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	mask_write_a: assert property (
		done && pwrite && paddr == `LA_CTL_ADDR |=> fwd_src_mask == $past(pwdata[15:0]))
		else $error("mask not written");
	fwd_stop_a: assert property (
		done && pwrite && paddr == `LA_CTL_ADDR && !pwdata[16] |=> ##[0:2] !fwd_enable)
		else $error("forwarding not stopped");
	fwd_code_a: assert property (
		done && !pwrite && paddr == `LA_STAT_ADDR |-> prdata[0] == prdata[2])
		else $error("forward state and ack disagree");
	node_info_a: assert property (
		done && !pwrite && paddr == `NODE_INFO_HI |-> prdata == PORT_LOGICAL_NUMBER)
		else $error("port number wrong");
	quiet_down_a: assert property (
		!link_active[0] && !$past(link_active[0]) |->
		$stable(credit_grant_tgl[0]) && $stable(credit_return_tgl[0]))
		else $error("credit moved on a down link");
	grant_cap_a: assert property (grants_q <= CREDITS)
		else $error("too many credits granted");
	up_c: cover property ($rose(link_active[0]));
	err_c: cover property (done && pslverr);
	fwd_c: cover property ($rose(fwd_enable));
endmodule // link_checker

bind link_handshake link_checker #(
	.NUM_LINKS(NUM_LINKS),
	.CREDITS(CREDITS),
	.PORT_LOGICAL_NUMBER(PORT_LOGICAL_NUMBER)
) u_link_checker (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .credit_grant_tgl(credit_grant_tgl),
	.credit_return_tgl(credit_return_tgl), .link_active(link_active),
	.fwd_src_mask(fwd_src_mask), .fwd_enable(fwd_enable)
);

// File: sim/remote_agent.sv
`timescale 1ns/1ps
module remote_agent (
	// clock and reset
	input  wire       pclk,
	input  wire       presetn,
	// device side
	input  wire       grant_in,
	input  wire       return_in,
	input  wire       active,
	// bench control
	input  wire       ready_en,
	input  wire       give_back,
	// toward the device
	output reg        ready,
	output reg        grant_out,
	output reg        return_out,
	output reg  [7:0] held,
	output reg  [7:0] owed
);
	reg       g_q;
	reg       r_q;
	reg [1:0] sent_q;
	wire      gnt = active && !give_back && sent_q < 2'h2;
	wire      rtn = active && give_back && held != 8'h00;
	// credit bookkeeping of the far agent
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			{ready, grant_out, return_out, g_q, r_q} <= 5'h00;
			{held, owed, sent_q} <= 18'h00000;
		end
		else
		begin
			ready <= ready_en;
			g_q <= grant_in;
			r_q <= return_in;
			sent_q <= active ? sent_q + {1'b0, gnt} : 2'h0;
			grant_out <= grant_out ^ gnt;
			return_out <= return_out ^ rtn;
			held <= held + {7'h00, grant_in != g_q} - {7'h00, rtn};
			owed <= owed + {7'h00, gnt} - {7'h00, return_in != r_q};
		end
	end
endmodule // remote_agent

// File: sim/link_handshake_tb.sv
`timescale 1ns/1ps
`include "link_handshake_defs.vh"
module link_handshake_tb;
	localparam  CREDITS = 8;
	localparam  PLN = 16'h005a; // arbitrary
	reg         pclk = 1'b0;
	reg         presetn = 1'b0;
	reg         psel = 1'b0;
	reg         penable = 1'b0;
	reg         pwrite = 1'b0;
	reg  [11:0] paddr = 12'h000;
	reg  [31:0] pwdata = 32'h0;
	reg  [2:0]  pcb = 3'h0;
	reg         ready_en = 1'b0;
	reg         give_back = 1'b0;
	wire        pready, pslverr, rdy, gnt, ret, fwd_enable;
	wire [31:0] prdata;
	wire [2:0]  grant_tgl, return_tgl, link_active;
	wire [15:0] fwd_src_mask;
	wire [7:0]  held, owed;
	reg  [31:0] r;
	reg         e;
	integer     mismatches = 0;
	integer     n_compared = 0;
	integer     i;
	always #2.5 pclk = ~pclk;
	link_handshake #(.CREDITS(CREDITS), .PORT_LOGICAL_NUMBER(PLN)) u_link_handshake (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .pending_copyback_flag(pcb),
		.remote_ready({3{rdy}}), .remote_grant_tgl({2'h0, gnt}), // one target port
		.remote_return_tgl({2'h0, ret}), .credit_grant_tgl(grant_tgl),
		.credit_return_tgl(return_tgl), .link_active(link_active),
		.fwd_src_mask(fwd_src_mask), .fwd_enable(fwd_enable));
	remote_agent u_remote_agent (
		.pclk(pclk), .presetn(presetn), .grant_in(grant_tgl[0]),
		.return_in(return_tgl[0]), .active(link_active[0]), .ready_en(ready_en),
		.give_back(give_back), .ready(rdy), .grant_out(gnt), .return_out(ret),
		.held(held), .owed(owed));
	// one apb transfer, then an idle cycle
	task apb(input [11:0] a, input w, input [31:0] d);
		begin
			psel <= 1'b1;
			paddr <= a;
			pwrite <= w;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			while (pready !== 1'b1)
				@(posedge pclk);
			r = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask
	task chk(input string nm, input [31:0] got, input [31:0] exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp)
			begin
				mismatches = mismatches + 1;
				$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
			end
		end
	endtask
	task rd(input [11:0] a, input [31:0] exp);
		begin
			apb(a, 1'b0, 32'h0);
			chk($sformatf("read %h", a), r, exp);
		end
	endtask
	// read again until the value shows, bounded
	task poll(input [11:0] a, input [31:0] exp);
		begin
			apb(a, 1'b0, 32'h0);
			for (i = 0; i < 40 && r !== exp; i = i + 1)
				apb(a, 1'b0, 32'h0);
			chk($sformatf("poll %h", a), r, exp);
		end
	endtask
	// same control word into both gateways of a link
	task wr2(input [11:0] base, input [31:0] d);
		begin
			apb(base + `RA_CTL_OFF, 1'b1, d);
			apb(base + `HA_CTL_OFF, 1'b1, d);
		end
	endtask
	task report_and_stop;
		begin
			$display("compared %0d mismatches %0d", n_compared, mismatches);
			if (mismatches == 0 && n_compared > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(`RA_STAT_OFF, 32'h2);
		rd(`HA_STAT_OFF, 32'h2);
		rd(`HA_CTL_OFF, 32'h0);
		wr2(12'h000, 32'h1);
		rd(`RA_CTL_OFF, 32'h1);
		rd(`HA_CTL_OFF, 32'h1);
		// request while the far side cannot take credits
		wr2(12'h000, 32'h3);
		repeat (10) @(posedge pclk);
		rd(`RA_STAT_OFF, 32'h2);
		ready_en <= 1'b1;
		poll(`RA_STAT_OFF, 32'h1);
		rd(`HA_STAT_OFF, 32'h1);
		$display("test link up done");
		wr2(12'h000, 32'h7);
		repeat (20) @(posedge pclk);
		chk("link_active", {29'h0, link_active}, 32'h1);
		chk("held", {24'h0, held}, CREDITS);
		$display("test go done");
		pcb <= 3'h1;
		rd(`RA_STAT_OFF, 32'h5);
		pcb <= 3'h0;
		rd(`RA_STAT_OFF, 32'h1);
		rd(`RA_CTL_OFF, 32'h7);
		rd(`HA_CTL_OFF, 32'h7);
		wr2(12'h000, 32'h5);
		rd(`RA_STAT_OFF, 32'h0);
		give_back <= 1'b1;
		poll(`RA_STAT_OFF, 32'h2);
		chk("owed", {24'h0, owed}, 32'h0);
		wr2(12'h000, 32'h1);
		give_back <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("link_active", {29'h0, link_active}, 32'h0);
		$display("test link down done");
		// a request in one gateway of link 1 and a request without allow on link 2 stay down
		pcb <= 3'h2;
		apb(12'h010, 1'b1, 32'h3);
		wr2(12'h020, 32'h2);
		repeat (10) @(posedge pclk);
		rd(12'h014, 32'h6);
		rd(12'h024, 32'h2);
		$display("test other links done");
		apb(`LA_CTL_ADDR, 1'b1, 32'h0001a5c3);
		chk("fwd_src_mask", {16'h0, fwd_src_mask}, 32'ha5c3);
		rd(`LA_STAT_ADDR, 32'h5);
		chk("fwd_enable", {31'h0, fwd_enable}, 32'h1);
		apb(`LA_CTL_ADDR, 1'b1, 32'h0000a5c3);
		rd(`LA_STAT_ADDR, 32'h0);
		rd(`NODE_INFO_HI, {16'h0, PLN});
		rd(`NODE_INFO_LO, 32'h0);
		apb(12'h200, 1'b1, 32'hffffffff);
		chk("pslverr", {31'h0, e}, 32'h1);
		rd(`LA_CTL_ADDR, 32'ha5c3);
		$display("test forwarding done");
		report_and_stop;
	end
	// watchdog against a hang
	initial
	begin
		repeat (20000) @(posedge pclk);
		mismatches = mismatches + 1;
		$display("CHECK FAILED watchdog expected end seen hang");
		report_and_stop;
	end
endmodule // link_handshake_tb
